// ### verilog/pcd_consts.svh
`ifndef PCD_CONSTS_SVH
`define PCD_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PCD_OFS_RISE 12'h000
`define PCD_OFS_FALL 12'h004
`define PCD_OFS_FLAG 12'h008
`define PCD_OFS_CTRL 12'h00c
`define PCD_OFS_EVT 12'h010
`define PCD_OFS_MASK 12'h014

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PCD_CTRL_MASTER_EN 0
`define PCD_CTRL_SUMMARY 1
`define PCD_EVT_CHANGE 0
`define PCD_EVT_WAKE 1
`define PCD_EVT_BITS 2

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define PCD_RST_PINS 8'h00
`define PCD_RST_EVT 2'h0
`define PCD_RST_DATA 32'h0000_0000
`define PCD_PRIME_CYCLES 3

`endif

// ### verilog/pcd_pkg.sv
package pcd_pkg;

	typedef logic [11:0] pcd_addr_t;
	typedef logic [31:0] pcd_data_t;

	// apb slave phase, one-hot
	typedef enum logic [1:0] {
		PCD_ST_IDLE = 2'b01,
		PCD_ST_ACC = 2'b10
	} pcd_apb_st_e;

endpackage : pcd_pkg

// ### verilog/pcd_reg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pcd_reg_if;
	import pcd_pkg::*;
	pcd_addr_t addr;
	pcd_data_t wdata;
	logic wr;
	pcd_data_t rdata;
	logic hit;

	modport bus (output addr, output wdata, output wr,
		input rdata, input hit);
	modport regs (input addr, input wdata, input wr,
		output rdata, output hit);
endinterface : pcd_reg_if

interface pcd_edge_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] rise;
	logic [WIDTH-1:0] fall;

	modport det (output rise, output fall);
	modport use_side (input rise, input fall);
endinterface : pcd_edge_if

`default_nettype wire

// ### verilog/pcd_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.svh"

module pcd_sync_edge #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] pins,
	pcd_edge_if.det edges
);
	import pcd_pkg::*;

	if (WIDTH < 1 || WIDTH > 8) begin : g_chk
		$error("pcd_sync_edge: WIDTH must be 1..8");
	end

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;
	logic [`PCD_PRIME_CYCLES-1:0] prime_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pins;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// pins tied high at reset must not look like a rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prime_q <= '0;
		end else begin
			prime_q <= {prime_q[`PCD_PRIME_CYCLES-2:0], 1'b1};
		end
	end

	assign edges.rise = prime_q[`PCD_PRIME_CYCLES-1] ?
		(sync_q & ~prev_q) : '0;
	assign edges.fall = prime_q[`PCD_PRIME_CYCLES-1] ?
		(~sync_q & prev_q) : '0;

endmodule : pcd_sync_edge

`default_nettype wire

// ### verilog/pcd_apb_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.svh"

module pcd_apb_slave (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire pcd_pkg::pcd_addr_t paddr,
	input wire pcd_pkg::pcd_data_t pwdata,
	output pcd_pkg::pcd_data_t prdata,
	output logic pready,
	output logic pslverr,
	pcd_reg_if.bus rif
);
	import pcd_pkg::*;

	pcd_apb_st_e state_q;
	logic setup;

	assign setup = psel && !penable && state_q == PCD_ST_IDLE;
	assign rif.addr = paddr;
	assign rif.wdata = pwdata;
	// commit only at the completing edge
	assign rif.wr = psel && penable && pwrite && pready && !pslverr;

	// ----------------------------------------------------------------------
	// phase tracking: one wait-free access cycle after setup
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= PCD_ST_IDLE;
		end else begin
			case (state_q)
				PCD_ST_IDLE: begin
					if (setup) begin
						state_q <= PCD_ST_ACC;
					end
				end
				PCD_ST_ACC: begin
					state_q <= PCD_ST_IDLE;
				end
				default: begin
					state_q <= PCD_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `PCD_RST_DATA;
		end else begin
			pready <= setup;
			pslverr <= setup && !rif.hit;
			// read data sampled in setup so it comes from a flop
			prdata <= (setup && !pwrite && rif.hit) ?
				rif.rdata : `PCD_RST_DATA;
		end
	end

endmodule : pcd_apb_slave

`default_nettype wire

// ### verilog/pcd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.svh"

// Function
// - each port pin can raise a change interrupt on rising or falling edge
// - any pin or combination of pins may be enabled at once
// - master enable clear still sets flags; irq then comes only from event status bits enabled in the mask register
// - separate rise and fall detectors; rise detected only when enabled
// - falling edges detected only while that pin's fall enable is set
// - both enables set detects both edge directions
// - enabled edge sets pin flag; requests interrupt if master enabled
// - summary flag is the OR of all pin change flags
// - writing zero to a flag bit clears that flag
// - edge during a clearing write leaves the flag set
// - with master enable set, a change event wakes from sleep
// - flags are updated before the first instruction after waking
// - rise and fall enables are 8-bit read/write, reset to zero
// - eight hardware-set read/write change flags, reset to zero

module pcd_top #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire pcd_pkg::pcd_addr_t paddr,
	input wire pcd_pkg::pcd_data_t pwdata,
	output pcd_pkg::pcd_data_t prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [WIDTH-1:0] second_io_port,
	input wire logic sleep_active,
	output logic change_irq_summary_flag,
	output logic wake_req,
	output logic irq
);
	import pcd_pkg::*;

	if (WIDTH < 1 || WIDTH > 8) begin : g_chk
		$error("pcd_top: WIDTH must be 1..8");
	end

	// ----------------------------------------------------------------------
	// pin sampling and edge detection
	// ----------------------------------------------------------------------
	pcd_edge_if #(.WIDTH(WIDTH)) eif ();
	pcd_reg_if rif ();

	pcd_sync_edge #(.WIDTH(WIDTH)) u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.pins(second_io_port),
		.edges(eif.det)
	);

	pcd_apb_slave u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.rif(rif.bus)
	);

	// ----------------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------------
	logic [WIDTH-1:0] rise_edge_enable_reg_q;
	logic [WIDTH-1:0] fall_edge_enable_reg_q;
	logic [WIDTH-1:0] pin_change_flag_reg_q;
	logic [WIDTH-1:0] pin_change_flag_reg_d;
	logic change_irq_master_enable_q;
	logic [`PCD_EVT_BITS-1:0] evt_q;
	logic [`PCD_EVT_BITS-1:0] evt_set;
	logic [`PCD_EVT_BITS-1:0] evt_mask_q;
	logic [WIDTH-1:0] hits;
	logic wake_now;

	function automatic logic wr_to(input pcd_addr_t a, input pcd_addr_t ofs,
		input logic wr);
		wr_to = wr && a == ofs;
	endfunction : wr_to

	function automatic pcd_data_t widen(input logic [WIDTH-1:0] v);
		widen = '0;
		widen[WIDTH-1:0] = v;
	endfunction : widen

	// any set of pins at once
	assign hits = (eif.rise & rise_edge_enable_reg_q) |
		(eif.fall & fall_edge_enable_reg_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_edge_enable_reg_q <= '0;
			fall_edge_enable_reg_q <= '0;
		end else begin
			if (wr_to(rif.addr, `PCD_OFS_RISE, rif.wr)) begin
				rise_edge_enable_reg_q <= rif.wdata[WIDTH-1:0];
			end
			if (wr_to(rif.addr, `PCD_OFS_FALL, rif.wr)) begin
				fall_edge_enable_reg_q <= rif.wdata[WIDTH-1:0];
			end
		end
	end

	// a coincident edge wins over the write
	always_comb begin
		pin_change_flag_reg_d = pin_change_flag_reg_q;
		if (wr_to(rif.addr, `PCD_OFS_FLAG, rif.wr)) begin
			pin_change_flag_reg_d = rif.wdata[WIDTH-1:0];
		end
		// enabled edge sets the pin flag
		pin_change_flag_reg_d = pin_change_flag_reg_d | hits;
	end

	// flags land in the same edge that raises the wake request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_change_flag_reg_q <= '0;
		end else begin
			pin_change_flag_reg_q <= pin_change_flag_reg_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			change_irq_master_enable_q <= 1'b0;
			evt_mask_q <= `PCD_RST_EVT;
		end else begin
			if (wr_to(rif.addr, `PCD_OFS_CTRL, rif.wr)) begin
				change_irq_master_enable_q <=
					rif.wdata[`PCD_CTRL_MASTER_EN];
			end
			if (wr_to(rif.addr, `PCD_OFS_MASK, rif.wr)) begin
				evt_mask_q <= rif.wdata[`PCD_EVT_BITS-1:0];
			end
		end
	end

	// ----------------------------------------------------------------------
	// summary, wake and interrupt
	// ----------------------------------------------------------------------
	// summary follows the next flag state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			change_irq_summary_flag <= 1'b0;
		end else begin
			change_irq_summary_flag <= |pin_change_flag_reg_d;
		end
	end

	// wake only with master enable set
	assign wake_now = sleep_active && change_irq_master_enable_q && |hits;

	// held until the core leaves sleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_req <= 1'b0;
		end else begin
			wake_req <= sleep_active && (wake_req || wake_now);
		end
	end

	always_comb begin
		evt_set = '0;
		evt_set[`PCD_EVT_CHANGE] = |hits;
		evt_set[`PCD_EVT_WAKE] = wake_now;
	end

	// write-one-to-clear, a same-cycle event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_q <= `PCD_RST_EVT;
		end else if (wr_to(rif.addr, `PCD_OFS_EVT, rif.wr)) begin
			evt_q <= (evt_q & ~rif.wdata[`PCD_EVT_BITS-1:0]) | evt_set;
		end else begin
			evt_q <= evt_q | evt_set;
		end
	end

	// master enable clear blocks the change request only
	// request while master enable is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= (change_irq_master_enable_q &&
				|pin_change_flag_reg_d) || |(evt_q & evt_mask_q);
		end
	end

	// ----------------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------------
	always_comb begin
		rif.hit = 1'b1;
		rif.rdata = '0;
		if (rif.addr == `PCD_OFS_RISE) begin
			rif.rdata = widen(rise_edge_enable_reg_q);
		end else if (rif.addr == `PCD_OFS_FALL) begin
			rif.rdata = widen(fall_edge_enable_reg_q);
		end else if (rif.addr == `PCD_OFS_FLAG) begin
			rif.rdata = widen(pin_change_flag_reg_q);
		end else if (rif.addr == `PCD_OFS_CTRL) begin
			rif.rdata[`PCD_CTRL_MASTER_EN] = change_irq_master_enable_q;
			rif.rdata[`PCD_CTRL_SUMMARY] = |pin_change_flag_reg_q;
		end else if (rif.addr == `PCD_OFS_EVT) begin
			rif.rdata[`PCD_EVT_BITS-1:0] = evt_q;
		end else if (rif.addr == `PCD_OFS_MASK) begin
			rif.rdata[`PCD_EVT_BITS-1:0] = evt_mask_q;
		end else begin
			rif.hit = 1'b0;
		end
	end

endmodule : pcd_top

`default_nettype wire

// ### test/pcd_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.svh"

module pcd_top_sva #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire pcd_pkg::pcd_addr_t paddr,
	input wire pcd_pkg::pcd_data_t pwdata,
	input wire pcd_pkg::pcd_data_t prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [WIDTH-1:0] second_io_port,
	input wire logic sleep_active,
	input wire logic change_irq_summary_flag,
	input wire logic wake_req,
	input wire logic irq
);
	import pcd_pkg::*;
	// ----
	// master enable shadow, updated at the same commit edge
	// ----
	logic master_q;
	wire logic wr_ok = psel && penable && pready && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_q <= 1'b0;
		end else if (wr_ok && paddr == `PCD_OFS_CTRL) begin
			master_q <= pwdata[`PCD_CTRL_MASTER_EN];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	AST_ERR_DECODE: assert property (pready |-> pslverr ==
		(paddr > `PCD_OFS_MASK || paddr[1:0] != 2'h0))
		else $error("error response mismatch");
	AST_SUM_STICKY: assert property ($fell(change_irq_summary_flag)
		|-> $past(wr_ok && paddr == `PCD_OFS_FLAG))
		else $error("summary fell without flag write");
	AST_IRQ_MASTER: assert property
		($past(master_q) && change_irq_summary_flag |-> irq)
		else $error("enabled flag gives no irq");
	AST_WAKE_CAUSE: assert property ($rose(wake_req) |->
		$past(sleep_active) && change_irq_summary_flag &&
		$past(master_q))
		else $error("wake without cause");
	AST_WAKE_END: assert property (!sleep_active |=> !wake_req)
		else $error("wake held after sleep");
	AST_CTRL_READ: assert property (pready && !pwrite &&
		paddr == `PCD_OFS_CTRL |-> prdata[0] == master_q)
		else $error("control read mismatch");
	cover property (irq);
	cover property ($rose(wake_req));
	cover property (pready && pslverr);
endmodule : pcd_top_sva

bind pcd_top pcd_top_sva #(.WIDTH(WIDTH)) u_sva (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .second_io_port(second_io_port),
	.sleep_active(sleep_active), .irq(irq), .wake_req(wake_req),
	.change_irq_summary_flag(change_irq_summary_flag));

`default_nettype wire

// ### test/pcd_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// port pin driver
// ----
module pcd_pin_drv #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	output logic [WIDTH-1:0] pins
);
	initial pins = '0;
	// levels move just after an edge; short holds model a fast pin
	task automatic drive(input logic [WIDTH-1:0] v, input int hold);
		@(posedge pclk);
		pins <= v;
		repeat (hold) @(posedge pclk);
	endtask : drive
endmodule : pcd_pin_drv

`default_nettype wire

// ### test/pin_change_interrupt_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcd_consts.svh"

module pin_change_interrupt_tb;
	import pcd_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, sleep_active;
	logic pready, pslverr, summary, wake_req, irq, err;
	pcd_addr_t paddr;
	pcd_data_t pwdata, prdata, rd;
	logic [7:0] pins;
	int errors, compares;

	pcd_top #(.WIDTH(8)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .second_io_port(pins), .irq(irq),
		.sleep_active(sleep_active), .wake_req(wake_req),
		.change_irq_summary_flag(summary));
	pcd_pin_drv #(.WIDTH(8)) u_pins (.pclk(pclk), .pins(pins));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// ----
	// helpers
	// ----
	task automatic complete_run();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input pcd_data_t seen,
		input pcd_data_t exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input pcd_addr_t a, input pcd_data_t d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// outputs fed by a written register move one edge after the commit
	task automatic wr(input pcd_addr_t a, input pcd_data_t d);
		apb(1'b1, a, d);
		repeat (2) @(posedge pclk);
	endtask : wr

	task automatic rdchk(input pcd_addr_t a, input pcd_data_t e,
		input string what);
		apb(1'b0, a, 32'h0);
		chk(what, rd, e);
	endtask : rdchk

	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		complete_run();
	end

	// ----
	// main sequence
	// ----
	initial begin
		{presetn, psel, penable, pwrite, sleep_active} = 5'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		errors = 0;
		compares = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdchk(12'(4 * i), 32'h0, "reset value");
		end
		wr(`PCD_OFS_RISE, 32'h0000_000f);
		wr(`PCD_OFS_FALL, 32'h0000_003c);
		rdchk(`PCD_OFS_FALL, 32'h0000_003c, "fall enables");
		u_pins.drive(8'hff, 6);
		rdchk(`PCD_OFS_FLAG, 32'h0000_000f, "rise flags");
		chk("summary", 32'(summary), 32'h1);
		chk("irq master off", 32'(irq), 32'h0);
		wr(`PCD_OFS_CTRL, 32'h1);
		chk("irq master on", 32'(irq), 32'h1);
		wr(`PCD_OFS_FLAG, 32'h0f & ~32'h0f);
		chk("summary clear", 32'(summary), 32'h0);
		u_pins.drive(8'h00, 6);
		rdchk(`PCD_OFS_FLAG, 32'h0000_003c, "fall flags");
		wr(`PCD_OFS_FLAG, 32'h3c & ~32'h04);
		rdchk(`PCD_OFS_FLAG, 32'h0000_0038, "masked clear");
		wr(`PCD_OFS_FLAG, 32'h0);
		wr(`PCD_OFS_CTRL, 32'h0);
		rdchk(`PCD_OFS_EVT, 32'h1, "event status");
		chk("irq unmasked", 32'(irq), 32'h0);
		wr(`PCD_OFS_MASK, 32'h1);
		chk("irq masked in", 32'(irq), 32'h1);
		wr(`PCD_OFS_EVT, 32'h1);
		chk("irq after w1c", 32'(irq), 32'h0);
		wr(`PCD_OFS_MASK, 32'h0);
		wr(`PCD_OFS_CTRL, 32'h1);
		sleep_active <= 1'b1;
		u_pins.drive(8'h21, 6);
		chk("wake", 32'(wake_req), 32'h1);
		rdchk(`PCD_OFS_FLAG, 32'h0000_0001, "sleep flags");
		rdchk(`PCD_OFS_EVT, 32'h3, "wake event");
		sleep_active <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("wake end", 32'(wake_req), 32'h0);
		apb(1'b1, 12'h018, 32'hffff_ffff);
		chk("unmapped error", 32'(err), 32'h1);
		rdchk(`PCD_OFS_CTRL, 32'h3, "control");
		complete_run();
	end
endmodule : pin_change_interrupt_tb

`default_nettype wire
